// ### tsm_defines.svh
// Register offsets, field positions and reset values of the timer slave-mode controller.
`ifndef TSM_DEFINES_SVH
`define TSM_DEFINES_SVH
`define TSM_OFF_RUN_CONTROL   12'h000
`define TSM_OFF_SLAVE_CONTROL 12'h008
`define TSM_OFF_COUNT         12'h00c
`define TSM_FUNC_LSB          0
`define TSM_FUNC_MSB          2
`define TSM_RSVD_BIT          3
`define TSM_TSEL_LSB          4
`define TSM_TSEL_MSB          6
`define TSM_RUN_BIT           0
`define TSM_RESET_FUNC        3'h0
`define TSM_RESET_TSEL        3'h0
`define TSM_RESET_COUNT       16'h0000
`define TSM_RESP_OKAY         2'h0
`define TSM_RESP_SLVERR       2'h2
`endif

// ### tsm_partner.sv
// Model of the trigger sources and quadrature channel inputs around the slave-mode controller.
`timescale 1ns/1ps
module tsm_partner (
    input  wire logic       i_clk,
    output logic [7:0]      o_src
);
    // Bit n is the source that trigger select code n picks; bits 6:5 double as the channels.
    logic [1:0] phase;
    // All sources start low so that no edge is seen straight out of reset.
    initial begin
        o_src = 8'h00;
        phase = 2'h0;
    end
    // Sets one source level just after an edge, as a same-domain timer output would.
    task automatic level(input int code, input logic v);
        @(posedge i_clk);
        o_src[code] <= v;
    endtask
    // One rising edge lasting a single cycle, then time for the counter to follow.
    task automatic pulse(input int code);
        level(code, 1'b1);
        level(code, 1'b0);
        repeat (3) @(posedge i_clk);
    endtask
    // Quadrature steps; upward steps make channel one lead channel two.
    task automatic quad(input bit up, input int n);
        repeat (n) begin
            phase = up ? phase + 2'h1 : phase - 2'h1;
            @(posedge i_clk);
            o_src[6:5] <= {phase[1], ^phase};
            repeat (3) @(posedge i_clk);
        end
    endtask
endmodule

// ### tsm_pkg.sv
// Types shared by the timer slave-mode controller.
package tsm_pkg;
    // Slave function codes, in field order 000 to 111.
    typedef enum logic [2:0] {
        TSM_OFF, TSM_ENC1, TSM_ENC2, TSM_ENC3, TSM_RESET, TSM_GATED, TSM_TRIGGER, TSM_EXTCLK
    } tsm_func_type;
    // Trigger source codes, in field order 000 to 111.
    typedef enum logic [2:0] {
        TSM_SRC_INTERNAL_TRIGGER_ZERO, TSM_SRC_INTERNAL_TRIGGER_ONE, TSM_SRC_INTERNAL_TRIGGER_TWO, TSM_SRC_INTERNAL_TRIGGER_THREE,
        TSM_SRC_EDGE, TSM_SRC_TI1, TSM_SRC_TI2, TSM_SRC_ETR
    } tsm_src_type;
endpackage

// ### tsm_top.sv
// Timer slave-mode controller with its counter and AXI4-Lite register slave.
`timescale 1ns/1ps
`include "tsm_defines.svh"
module tsm_top #(
    parameter int COUNT_W = 16
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire logic [3:0]           i_internal_trigger,
    input  wire logic                 i_channel_one_edge_detector,
    input  wire logic                 i_channel_one_filtered_input,
    input  wire logic                 i_channel_two_filtered_input,
    input  wire logic                 i_filtered_external_trigger,
    input  wire logic [11:0]          i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [11:0]          i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic [COUNT_W-1:0]        o_count,
    output logic                      o_direction_down,
    output logic                      o_update_event,
    output logic                      o_counter_running,
    output tsm_pkg::tsm_func_type     o_slave_function
);
    import tsm_pkg::*;

    tsm_func_type       slave_function_select;  // Function field of the slave control register.
    tsm_src_type        trigger_source_select;  // Source field of the slave control register.
    logic               counter_run_bit;        // Counter run bit; hardware may also set it.
    logic               ti1_q;                  // Channel-one level one cycle ago.
    logic               ti2_q;                  // Channel-two level one cycle ago.
    logic               trg_q;                  // Selected trigger one cycle ago.
    logic               selected_trigger_input; // Output of the source multiplexer.
    logic               ti1_edge;               // Any edge on channel one.
    logic               ti2_edge;               // Any edge on channel two.
    logic               trg_rise;               // Rising edge on the selected trigger.
    logic               tick;                   // Counter advances this cycle.
    logic               down;                   // Direction for this tick.
    logic               clear;                  // Counter reinitialise this cycle.
    logic               wr_go;                  // Write address and data both taken now.
    logic               rd_go;                  // Read address taken now.
    logic               rd_smctrl;              // Last read targeted the slave control register.

    // Sources are filtered logic on the timer clock, so they are sampled without synchronisers.
    always_comb begin
        case (trigger_source_select)
            TSM_SRC_INTERNAL_TRIGGER_ZERO: selected_trigger_input = i_internal_trigger[0];
            TSM_SRC_INTERNAL_TRIGGER_ONE: selected_trigger_input = i_internal_trigger[1];
            TSM_SRC_INTERNAL_TRIGGER_TWO: selected_trigger_input = i_internal_trigger[2];
            TSM_SRC_INTERNAL_TRIGGER_THREE: selected_trigger_input = i_internal_trigger[3];
            TSM_SRC_EDGE: selected_trigger_input = i_channel_one_edge_detector;
            TSM_SRC_TI1:  selected_trigger_input = i_channel_one_filtered_input;
            TSM_SRC_TI2:  selected_trigger_input = i_channel_two_filtered_input;
            default:      selected_trigger_input = i_filtered_external_trigger;
        endcase
    end

    // Previous levels feed the edge detectors.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ti1_q <= 1'b0;
            ti2_q <= 1'b0;
            trg_q <= 1'b0;
        end else begin
            ti1_q <= i_channel_one_filtered_input;
            ti2_q <= i_channel_two_filtered_input;
            // The edge detector follows a source change too, which is why software switches
            // the source only with the function field at zero.
            trg_q <= selected_trigger_input;
        end
    end

    assign ti1_edge = i_channel_one_filtered_input ^ ti1_q;
    assign ti2_edge = i_channel_two_filtered_input ^ ti2_q;
    assign trg_rise = selected_trigger_input & ~trg_q;
    assign wr_go    = i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
    assign rd_go    = i_arvalid & ~o_arready & ~o_rvalid;

    // Function decode: every mode needs the run bit to count; only the reset-mode clear works without it.
    always_comb begin
        tick  = 1'b0;
        down  = o_direction_down;
        clear = 1'b0;
        case (slave_function_select)
            TSM_OFF: begin
                tick = counter_run_bit;
            end
            TSM_ENC1: begin
                tick = counter_run_bit & ti2_edge;
                down = i_channel_two_filtered_input ~^ i_channel_one_filtered_input;
            end
            TSM_ENC2: begin
                tick = counter_run_bit & ti1_edge;
                down = i_channel_one_filtered_input ^ i_channel_two_filtered_input;
            end
            TSM_ENC3: begin
                // Simultaneous edges are not a legal quadrature step, so they are ignored.
                tick = counter_run_bit & (ti1_edge ^ ti2_edge);
                down = ti2_edge ? (i_channel_two_filtered_input ~^ i_channel_one_filtered_input)
                                : (i_channel_one_filtered_input ^ i_channel_two_filtered_input);
            end
            TSM_RESET: begin
                tick  = counter_run_bit & ~trg_rise;
                clear = trg_rise;
            end
            TSM_GATED: begin
                tick = counter_run_bit & selected_trigger_input;
            end
            TSM_TRIGGER: begin
                tick = counter_run_bit;
            end
            TSM_EXTCLK: begin
                tick = counter_run_bit & trg_rise;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
    end

    // The counter itself; gating only holds it and never clears it.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_count          <= `TSM_RESET_COUNT;
            o_direction_down <= 1'b0;
            o_update_event   <= 1'b0;
        end else begin
            o_update_event <= clear;
            if (clear) begin
                o_count <= `TSM_RESET_COUNT;
            end else if (tick) begin
                o_direction_down <= down;
                o_count          <= down ? o_count - 1'b1 : o_count + 1'b1;
            end
        end
    end

    // Register writes; a trigger-mode start wins over a software clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slave_function_select <= TSM_OFF;
            trigger_source_select <= TSM_SRC_INTERNAL_TRIGGER_ZERO;
            counter_run_bit       <= 1'b0;
        end else begin
            if (wr_go && i_wstrb[0]) begin
                if (i_awaddr == `TSM_OFF_SLAVE_CONTROL) begin
                    // Bit 3 has no storage, so writes to it vanish.
                    slave_function_select <= tsm_func_type'(i_wdata[`TSM_FUNC_MSB:`TSM_FUNC_LSB]);
                    trigger_source_select <= tsm_src_type'(i_wdata[`TSM_TSEL_MSB:`TSM_TSEL_LSB]);
                end
                if (i_awaddr == `TSM_OFF_RUN_CONTROL) begin
                    counter_run_bit <= i_wdata[`TSM_RUN_BIT];
                end
            end
            if (slave_function_select == TSM_TRIGGER && trg_rise) begin
                counter_run_bit <= 1'b1;
            end
        end
    end

    // Write handshake: both channels taken together; the response is raised only after the
    // ready pulse, so that it follows both address and data handshakes as the bus demands.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `TSM_RESP_OKAY;
        end else begin
            o_awready <= wr_go;
            o_wready  <= wr_go;
            // The response code is judged at the taking edge and held until it is shown.
            if (wr_go) begin
                o_bresp  <= (i_awaddr == `TSM_OFF_RUN_CONTROL || i_awaddr == `TSM_OFF_SLAVE_CONTROL ||
                             i_awaddr == `TSM_OFF_COUNT) ? `TSM_RESP_OKAY : `TSM_RESP_SLVERR;
            end
            // Valid rises at the handshake edge, when the master still holds both valids.
            if (o_awready) begin
                o_bvalid <= 1'b1;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Read handshake: data latched when the address is taken, valid after the address handshake.
    // Unmapped reads give SLVERR.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `TSM_RESP_OKAY;
            rd_smctrl <= 1'b0;
        end else begin
            o_arready <= rd_go;
            // Valid must not come before the address handshake, so it follows the ready pulse.
            if (o_arready) begin
                o_rvalid <= 1'b1;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
            if (rd_go) begin
                o_rresp   <= `TSM_RESP_OKAY;
                rd_smctrl <= (i_araddr == `TSM_OFF_SLAVE_CONTROL);
                case (i_araddr)
                    `TSM_OFF_RUN_CONTROL:   o_rdata <= {31'h00000000, counter_run_bit};
                    `TSM_OFF_SLAVE_CONTROL: o_rdata <= {25'h0000000, trigger_source_select,
                                                        1'b0, slave_function_select};
                    `TSM_OFF_COUNT:         o_rdata <= {{(32-COUNT_W){1'b0}}, o_count};
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= `TSM_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Status mirrors, straight from flip-flops.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_counter_running <= 1'b0;
            o_slave_function  <= TSM_OFF;
        end else begin
            o_counter_running <= counter_run_bit;
            o_slave_function  <= slave_function_select;
        end
    end

    off_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_OFF && counter_run_bit |=> o_count != $past(o_count))
        else $error("Counter idle with slave mode off and run bit set.");
    enc_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_ENC1 && !ti2_edge |=> $stable(o_count))
        else $error("Encoder 1 counted without a channel-two edge.");
    enc_two_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_ENC2 && counter_run_bit && ti1_edge
        && !i_channel_two_filtered_input && i_channel_one_filtered_input |=> o_count == $past(o_count) - 1'b1)
        else $error("Encoder 2 counted in the wrong direction.");
    enc_three_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_ENC3 && !ti1_edge && !ti2_edge |=> $stable(o_count))
        else $error("Encoder 3 counted without an edge.");
    reset_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_RESET && trg_rise |=> o_count == `TSM_RESET_COUNT && o_update_event)
        else $error("Reset mode did not clear the counter.");
    gated_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_GATED && !selected_trigger_input |=> $stable(o_count))
        else $error("Gated mode moved while the trigger was low.");
    trigger_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_TRIGGER && trg_rise |=> counter_run_bit ##1 o_counter_running)
        else $error("Trigger mode did not start the counter.");
    ext_clock_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_function_select == TSM_EXTCLK && !trg_rise |=> $stable(o_count))
        else $error("External clock mode advanced without a trigger rise.");
    source_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        trigger_source_select == TSM_SRC_INTERNAL_TRIGGER_ONE |-> selected_trigger_input == i_internal_trigger[1])
        else $error("Source 001 does not pick internal trigger one.");
    source_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        trigger_source_select == TSM_SRC_ETR |-> selected_trigger_input == i_filtered_external_trigger)
        else $error("Source 111 does not pick the external trigger.");
    reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_rvalid && rd_smctrl |-> o_rdata[`TSM_RSVD_BIT] == 1'b0)
        else $error("Reserved bit 3 read back as one.");
endmodule

// ### tsm_top_tb.sv
// Self-checking bench for the timer slave-mode controller.
`timescale 1ns/1ps
`include "tsm_defines.svh"
module tsm_top_tb;
    import tsm_pkg::*;
    logic         i_clk   = 1'b0;
    logic         i_rst_b = 1'b0;
    logic [11:0]  awaddr  = 12'h000;
    logic [11:0]  araddr  = 12'h000;
    logic [31:0]  wdata   = 32'h0;
    logic         awvalid = 1'b0;
    logic         wvalid  = 1'b0;
    logic         bready  = 1'b0;
    logic         arvalid = 1'b0;
    logic         rready  = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, upd, run, down;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    logic [15:0]  count, c0, n;
    logic [7:0]   src;
    tsm_func_type func;
    int           mismatches = 0;
    int           compares   = 0;
    // Free-running 50 MHz timer clock.
    always #10 i_clk = ~i_clk;
    tsm_partner partner_u (.i_clk(i_clk), .o_src(src));
    tsm_top #(.COUNT_W(16)) dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_internal_trigger(src[3:0]),
        .i_channel_one_edge_detector(src[4]), .i_channel_one_filtered_input(src[5]),
        .i_channel_two_filtered_input(src[6]), .i_filtered_external_trigger(src[7]),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .o_count(count), .o_direction_down(down),
        .o_update_event(upd), .o_counter_running(run), .o_slave_function(func));
    // Prints the tallies and the verdict, then ends the run.
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Counts one comparison and reports it at once if it failed.
    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    // One AXI4-Lite write; each channel is dropped at the edge its ready is seen.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        check(k < 20 && bresp === er && awvalid === 1'b0 && wvalid === 1'b0, "write response");
        if (k >= 20) close_out();
    endtask
    // One AXI4-Lite read, compared with the expected word and response.
    task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        check(k < 20 && rdata === ed && rresp === er && arvalid === 1'b0, "read data or response");
        if (k >= 20) close_out();
    endtask
    function automatic logic [31:0] smc(input tsm_src_type s, input tsm_func_type f);
        return {25'h0, s, 1'b0, f};
    endfunction
    // The source is only ever changed with the function parked at zero, to avoid false edges.
    task automatic set_mode(input tsm_src_type s, input tsm_func_type f);
        wr(`TSM_OFF_SLAVE_CONTROL, smc(s, TSM_OFF), `TSM_RESP_OKAY);
        wr(`TSM_OFF_SLAVE_CONTROL, smc(s, f), `TSM_RESP_OKAY);
        check(func === f, "function output");
        tick(2);
        c0 = count;
    endtask
    // Reset values, an unmapped place, the reserved bit and the read-only count.
    task automatic t_reset();
        rdc(`TSM_OFF_SLAVE_CONTROL, 32'h0, `TSM_RESP_OKAY);
        rdc(`TSM_OFF_RUN_CONTROL, 32'h0, `TSM_RESP_OKAY);
        rdc(12'h010, 32'h0, `TSM_RESP_SLVERR);
        wr(12'h010, 32'h1, `TSM_RESP_SLVERR);
        wr(`TSM_OFF_SLAVE_CONTROL, 32'h8, `TSM_RESP_OKAY);
        rdc(`TSM_OFF_SLAVE_CONTROL, 32'h0, `TSM_RESP_OKAY);
        wr(`TSM_OFF_COUNT, 32'h5, `TSM_RESP_OKAY);
        rdc(`TSM_OFF_COUNT, 32'h0, `TSM_RESP_OKAY);
    endtask
    // With slave mode off the counter follows the run bit one step per cycle.
    task automatic t_free();
        wr(`TSM_OFF_RUN_CONTROL, 32'h1, `TSM_RESP_OKAY);
        tick(2);
        c0 = count;
        tick(10);
        check(count === c0 + 16'd10, "free run step");
        wr(`TSM_OFF_RUN_CONTROL, 32'h0, `TSM_RESP_OKAY);
        tick(2);
        c0 = count;
        tick(5);
        check(count === c0, "stopped counter moved");
        wr(`TSM_OFF_RUN_CONTROL, 32'h1, `TSM_RESP_OKAY);
    endtask
    // Every source code as external clock; a neighbour source must not count.
    task automatic t_extclk();
        for (int s = 0; s < 8; s++) begin
            set_mode(tsm_src_type'(s), TSM_EXTCLK);
            partner_u.pulse(s);
            partner_u.pulse(s);
            partner_u.pulse(s ^ 1);
            check(count === c0 + 16'd2, "external clock count");
        end
    endtask
    // Channel one leading counts down in all encoder modes; mode 3 counts every edge.
    task automatic t_enc();
        for (int m = 1; m < 4; m++) begin
            set_mode(TSM_SRC_INTERNAL_TRIGGER_ZERO, tsm_func_type'(m));
            n = (m == 3) ? 16'd8 : 16'd4;
            partner_u.quad(1'b1, 8);
            check(count === c0 - n && down === 1'b1, "encoder down count");
            c0 = count;
            partner_u.quad(1'b0, 8);
            check(count === c0 + n && down === 1'b0, "encoder up count");
        end
    endtask
    // Gating holds and resumes the count without clearing it.
    task automatic t_gated();
        set_mode(TSM_SRC_INTERNAL_TRIGGER_ZERO, TSM_GATED);
        partner_u.level(0, 1'b1);
        tick(5);
        partner_u.level(0, 1'b0);
        tick(4);
        check(count === c0 + 16'd6, "gated count");
        c0 = count;
        tick(5);
        check(count === c0, "gated hold");
        partner_u.level(0, 1'b1);
        tick(2);
        partner_u.level(0, 1'b0);
        tick(4);
        check(count === c0 + 16'd3, "gated resume");
    endtask
    // A trigger rise clears the running counter and raises one update pulse.
    task automatic t_rstmode();
        int k;
        set_mode(TSM_SRC_INTERNAL_TRIGGER_ZERO, TSM_RESET);
        tick(4);
        partner_u.level(0, 1'b1);
        partner_u.level(0, 1'b0);
        for (k = 0; k < 10; k++) begin
            @(posedge i_clk);
            if (upd === 1'b1) break;
        end
        check(k < 10 && count === 16'h0, "reset mode clear");
        @(posedge i_clk);
        check(upd === 1'b0, "update pulse too long");
    endtask
    // A trigger rise sets the run bit of a stopped counter.
    task automatic t_trig();
        wr(`TSM_OFF_RUN_CONTROL, 32'h0, `TSM_RESP_OKAY);
        set_mode(TSM_SRC_INTERNAL_TRIGGER_ZERO, TSM_TRIGGER);
        tick(4);
        check(count === c0 && run === 1'b0, "counter ran early");
        partner_u.pulse(0);
        c0 = count;
        tick(4);
        check(run === 1'b1 && count === c0 + 16'd4, "trigger start");
        rdc(`TSM_OFF_RUN_CONTROL, 32'h1, `TSM_RESP_OKAY);
    endtask
    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial begin
        tick(16);
        i_rst_b <= 1'b1;
        t_reset();
        t_free();
        t_extclk();
        t_enc();
        t_gated();
        t_rstmode();
        t_trig();
        close_out();
    end
endmodule
